// file: hdl/crc_pkg.sv
// package for the current reference control register block
// assumes an 8-bit special function register bus inside the device core
`default_nettype none
package crc_pkg;
  // register location
  localparam logic [7:0] CRC_ADDR = 8'hB9;
  localparam logic [3:0] CRC_PAGE = 4'h0;
  localparam logic [7:0] CRC_RESET = 8'h00;
  // field positions
  localparam int CRC_DIR_BIT = 7;
  localparam int CRC_RANGE_BIT = 6;
  localparam int CRC_COUNT_MSB = 5;
  localparam int CRC_COUNT_W = 6;
  // step sizes in microamps and resulting full-scale values
  localparam logic [3:0] CRC_STEP_LOW_UA = 4'h1;
  localparam logic [3:0] CRC_STEP_HIGH_UA = 4'h8;
  localparam logic [8:0] CRC_MAX_LOW_UA = 9'h03F;
  localparam logic [8:0] CRC_MAX_HIGH_UA = 9'h1F8;

  // controls handed to the analog current cell
  typedef struct packed {
    logic sink;
    logic high_range;
    logic [5:0] step_count;
    logic enable;
  } crc_cell_t;
endpackage : crc_pkg
`default_nettype wire

// file: hdl/crc_ctrl.sv
// current reference control register and analog cell drive
// assumes a synchronous sfr bus: one-cycle write strobe, combinational read data
// assumes the analog cell takes static levels and needs no handshake
`default_nettype none
module crc_ctrl
  import crc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // special function register bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic [3:0] sfr_page_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // analog current cell
  output crc_cell_t cell_out,
  output logic [8:0] magnitude_ua_out
);

  // ----------------------------------------
  // local sizes and reset levels
  // ----------------------------------------
  // nine bits hold the largest product, 63 steps of 8 microamps
  localparam int MAG_W = 9;
  // one guard bit on each partial sum, cut off once the sum is known to fit
  localparam int SUM_W = MAG_W + 1;
  // cell reset levels follow the register's reset byte, so both agree after reset
  localparam logic RST_SINK = CRC_RESET[CRC_DIR_BIT];
  localparam logic RST_HIGH_RANGE = CRC_RESET[CRC_RANGE_BIT];
  localparam logic [CRC_COUNT_W-1:0] RST_STEP_COUNT = CRC_RESET[CRC_COUNT_MSB:0];
  localparam logic RST_ENABLE = (RST_STEP_COUNT != '0);

  // ----------------------------------------
  // address and page match
  // ----------------------------------------
  wire addr_match;
  wire page_match;
  wire sel;
  wire wr_hit;
  wire rd_hit;

  assign addr_match = (sfr_addr_in == CRC_ADDR);
  assign page_match = (sfr_page_in == CRC_PAGE);
  assign sel = addr_match && page_match;
  assign wr_hit = sel && sfr_wr_in;
  assign rd_hit = sel && sfr_rd_in;
  assign sfr_hit_out = wr_hit || rd_hit;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [7:0] current_reference_control;
  logic [7:0] next_current_reference_control;

  // every bit is read/write, so a write replaces the whole byte
  assign next_current_reference_control = wr_hit
    ? sfr_wdata_in
    : current_reference_control;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      current_reference_control <= CRC_RESET;
    else
      current_reference_control <= next_current_reference_control;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unselected reads return zero so the core can or the read buses together
  assign sfr_rdata_out = rd_hit ? current_reference_control : 8'h00;

  // ----------------------------------------
  // field split
  // ----------------------------------------
  wire dir_sink;
  wire range_high;
  wire [CRC_COUNT_W-1:0] count;
  wire count_nz;

  assign dir_sink = current_reference_control[CRC_DIR_BIT];
  assign range_high = current_reference_control[CRC_RANGE_BIT];
  assign count = current_reference_control[CRC_COUNT_MSB:0];
  // direction and range bits play no part: a zero count always means off
  assign count_nz = (count != 6'h00);

  // ----------------------------------------
  // step size
  // ----------------------------------------
  wire [MAG_W-1:0] step_low;
  wire [MAG_W-1:0] step_high;
  wire [MAG_W-1:0] step_ua;

  assign step_low = MAG_W'(CRC_STEP_LOW_UA);
  assign step_high = MAG_W'(CRC_STEP_HIGH_UA);
  assign step_ua = range_high ? step_high : step_low;

  // ----------------------------------------
  // magnitude, one shifted step per count bit
  // ----------------------------------------
  // shift-and-add keeps the product small; no general multiplier is built
  wire [MAG_W-1:0] partial [CRC_COUNT_W];
  wire [SUM_W-1:0] sum_ext [CRC_COUNT_W];
  wire [MAG_W-1:0] running [CRC_COUNT_W+1];

  assign running[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < CRC_COUNT_W; gi = gi + 1)
    begin : g_step
      assign partial[gi] = count[gi] ? (step_ua << gi) : '0;
      assign sum_ext[gi] = {1'b0, running[gi]} + {1'b0, partial[gi]};
      // the full-scale sum is 504, so the guard bit is always zero
      assign running[gi + 1] = sum_ext[gi][MAG_W-1:0];
    end
  endgenerate

  // ----------------------------------------
  // full-scale limit
  // ----------------------------------------
  // a six-bit count cannot pass full scale; the clamp keeps a wider count
  // field from reporting more than full scale on magnitude_ua_out; cell_out takes the count unclamped
  wire [MAG_W-1:0] full_scale;
  wire [MAG_W-1:0] raw_magnitude;
  wire [MAG_W-1:0] next_magnitude;

  assign full_scale = range_high ? CRC_MAX_HIGH_UA : CRC_MAX_LOW_UA;
  assign raw_magnitude = running[CRC_COUNT_W];
  assign next_magnitude = (raw_magnitude > full_scale) ? full_scale : raw_magnitude;

  // ----------------------------------------
  // next cell levels
  // ----------------------------------------
  wire next_cell_sink;
  wire next_cell_high_range;
  wire [CRC_COUNT_W-1:0] next_cell_step_count;
  wire next_cell_enable;

  assign next_cell_sink = dir_sink;
  assign next_cell_high_range = range_high;
  assign next_cell_step_count = count;
  // polarity and range still pass through while off, so the cell settles early
  assign next_cell_enable = count_nz;

  // ----------------------------------------
  // cell drive flip-flops
  // ----------------------------------------
  // the analog cell sees static levels that only move one edge after a write;
  // one short flop group per control line keeps every reset level explicit
  logic cell_sink;
  logic cell_high_range;
  logic [CRC_COUNT_W-1:0] cell_step_count;
  logic cell_enable;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      cell_sink <= RST_SINK;
    else
      cell_sink <= next_cell_sink;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      cell_high_range <= RST_HIGH_RANGE;
    else
      cell_high_range <= next_cell_high_range;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      cell_step_count <= RST_STEP_COUNT;
    else
      cell_step_count <= next_cell_step_count;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      cell_enable <= RST_ENABLE;
    else
      cell_enable <= next_cell_enable;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      magnitude_ua_out <= '0;
    else
      magnitude_ua_out <= next_magnitude;
  end

  // ----------------------------------------
  // outputs to the analog cell
  // ----------------------------------------
  // the struct keeps the four control lines together on their way to the cell
  assign cell_out = '{
    sink: cell_sink,
    high_range: cell_high_range,
    step_count: cell_step_count,
    enable: cell_enable
  };

endmodule : crc_ctrl
`default_nettype wire

// file: tb/crc_asserts.sv
// port checker for crc_ctrl, bound to every instance
// assumes the package is compiled first and the clock runs throughout
`default_nettype none
module crc_asserts import crc_pkg::*; (input wire logic clk_sys_in, rstn_in, sfr_wr_in,
  sfr_rd_in, sfr_hit_out, input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic [3:0] sfr_page_in, input wire crc_cell_t cell_out,
  input wire logic [8:0] magnitude_ua_out);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rstn_in);
wire sel = sfr_addr_in == CRC_ADDR && sfr_page_in == CRC_PAGE;
sequence s_wr; sel && sfr_wr_in ##1 !sfr_wr_in; endsequence
property p_dir; s_wr |=> cell_out.sink == $past(sfr_wdata_in[7], 2); endproperty
a_dir: assert property (p_dir) else $error("sink bad");
property p_rng; s_wr |=> cell_out.high_range == $past(sfr_wdata_in[6], 2); endproperty
a_rng: assert property (p_rng) else $error("range bad");
property p_cnt; s_wr |=> cell_out.step_count == $past(sfr_wdata_in[5:0], 2); endproperty
a_cnt: assert property (p_cnt) else $error("count bad");
property p_en; cell_out.enable == (cell_out.step_count != 6'h00); endproperty
a_en: assert property (p_en) else $error("enable bad");
property p_mag; magnitude_ua_out == cell_out.step_count * (cell_out.high_range ? 9'h8 : 9'h1);
endproperty
a_mag: assert property (p_mag) else $error("magnitude bad");
property p_rd; sel && sfr_wr_in ##1 sfr_rd_in && sel |-> sfr_rdata_out == $past(sfr_wdata_in);
endproperty
a_rd: assert property (p_rd) else $error("readback bad");
property p_hit; sfr_hit_out == (sel && (sfr_rd_in || sfr_wr_in)); endproperty
a_hit: assert property (p_hit) else $error("hit bad");
property p_hold; !sfr_wr_in [*2] |=> $stable(cell_out); endproperty
a_hold: assert property (p_hold) else $error("cell moved");
endmodule : crc_asserts
bind crc_ctrl crc_asserts crc_asserts_i(
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in),
  .sfr_hit_out(sfr_hit_out),
  .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out),
  .sfr_page_in(sfr_page_in),
  .cell_out(cell_out),
  .magnitude_ua_out(magnitude_ua_out)
);
`default_nettype wire

// file: tb/test_crc_ctrl.sv
// bench for crc_ctrl: bus driven at falling edge, checker bound beside it
// assumes the checker is bound in from its own file and the package compiles first
`default_nettype none
module test_crc_ctrl import crc_pkg::*;;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys_in=0, rstn_in=0, sfr_wr_in=0, sfr_rd_in=0, sfr_hit_out;
logic [7:0] sfr_addr_in=CRC_ADDR, sfr_wdata_in=8'h00, sfr_rdata_out;
logic [3:0] sfr_page_in=CRC_PAGE;
logic [8:0] magnitude_ua_out;
crc_cell_t cell_out;
logic [7:0] vals[7] = '{8'hC5, 8'h7F, 8'h40, 8'hBF, 8'h80, 8'h00, 8'h3F};
int n_fail=0, samples_checked=0;
always #20 clk_sys_in = ~clk_sys_in;
crc_ctrl crc_ctrl_i(
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_page_in(sfr_page_in),
  .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out),
  .cell_out(cell_out),
  .magnitude_ua_out(magnitude_ua_out)
);
task chk(input string s, input logic [8:0] e, input logic [8:0] g);
  samples_checked++;
  if (e !== g)
  begin
    n_fail++;
    $display("BAD %s exp %h got %h", s, e, g);
  end
endtask : chk
task wr(logic [7:0] a, d, logic [3:0] p);
  @(negedge clk_sys_in) {sfr_addr_in, sfr_page_in, sfr_wdata_in, sfr_wr_in} = {a, p, d, 1'b1};
  @(negedge clk_sys_in) {sfr_addr_in, sfr_page_in, sfr_wr_in, sfr_rd_in} = {CRC_ADDR, CRC_PAGE, 2'b01};
  @(negedge clk_sys_in);
endtask : wr
task t_val(logic [7:0] d);
  wr(CRC_ADDR, d, CRC_PAGE);
  chk("rdata", 9'(d), 9'(sfr_rdata_out));
  chk("hit", 9'h001, 9'(sfr_hit_out));
  chk("cell", {d, d[5:0] != 6'h00}, cell_out);
  chk("mag", d[5:0] * (d[6] ? 9'h8 : 9'h1), magnitude_ua_out);
  $display("value %h done", d);
endtask : t_val
task t_ref;
  wr(8'hB8, 8'h55, CRC_PAGE);
  wr(CRC_ADDR, 8'h2A, 4'h1);
  chk("kept", 9'h03F, 9'(sfr_rdata_out));
  sfr_addr_in = 8'hB8;
  #1 chk("other", 9'h000, {sfr_hit_out, sfr_rdata_out});
  $display("refusal done");
endtask : t_ref
task t_rst;
  @(negedge clk_sys_in);
  sfr_addr_in = CRC_ADDR;
  rstn_in = 1'b0;
  repeat (2) @(negedge clk_sys_in);
  rstn_in = 1'b1;
  chk("reset reg", 9'h000, 9'(sfr_rdata_out));
  chk("reset cell", 9'h000, cell_out);
  chk("reset mag", 9'h000, magnitude_ua_out);
  $display("mid-run reset done");
endtask : t_rst
task print_verdict;
  $display("checks %0d fails %0d", samples_checked, n_fail);
  if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
  else $display("Some tests failed");
  $finish;
endtask : print_verdict
initial
begin
  repeat (5) @(negedge clk_sys_in);
  rstn_in = 1;
  chk("reset", 9'h000, cell_out);
  foreach (vals[i]) t_val(vals[i]);
  t_ref;
  t_rst;
  t_val(8'hE1);
  print_verdict;
end
endmodule : test_crc_ctrl
`default_nettype wire
